//--- common/sam_pkg.sv
package sam_pkg;

  // Timing base.
  localparam int CLK_PERIOD_NS = 4;
  localparam int PWR_LOSS_MS = 60;
  localparam int PWR_LOSS_CYCLES = PWR_LOSS_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LOCK_TICK_US = 1000;
  localparam int LOCK_TICK_CYCLES = LOCK_TICK_US * 1000 / CLK_PERIOD_NS;

  // Widths.
  localparam int NUM_ALARMS = 28;
  localparam int NUM_WARNS = 13;
  localparam int IDX_W = 5;
  localparam int CODE_W = 12;
  localparam int LOAD_W = 8;
  localparam int TICK_W = 16;

  // Thermal lockout: base ticks plus averaged load, load filter shift.
  localparam logic [TICK_W-1:0] LOCK_BASE_TICKS = 16'h03e8;
  localparam int LOAD_SHIFT = 4;

  // Indices of the alarm that the undervoltage detector feeds.
  localparam logic [IDX_W-1:0] IDX_UNDERVOLT = 5'h00;

  // Clear classes.
  localparam logic [1:0] CLR_POWER = 2'h0;
  localparam logic [1:0] CLR_RESET = 2'h1;
  localparam logic [1:0] CLR_RX1 = 2'h2;
  localparam logic [1:0] CLR_THERMAL = 2'h3;

  // Display code blank value.
  localparam logic [CODE_W-1:0] CODE_NONE = 12'h000;

  typedef enum logic {ST_RUN, ST_ALARM} sam_state_t;

  // Display code of each alarm index.
  function automatic logic [CODE_W-1:0] alarmCode(input logic [IDX_W-1:0] idx);
    case (idx)
      5'h00: alarmCode = 12'h010;
      5'h01: alarmCode = 12'h012;
      5'h02: alarmCode = 12'h013;
      5'h03: alarmCode = 12'h015;
      5'h04: alarmCode = 12'h016;
      5'h05: alarmCode = 12'h017;
      5'h06: alarmCode = 12'h019;
      5'h07: alarmCode = 12'h01a;
      5'h08: alarmCode = 12'h020;
      5'h09: alarmCode = 12'h024;
      5'h0a: alarmCode = 12'h025;
      5'h0b: alarmCode = 12'h030;
      5'h0c: alarmCode = 12'h031;
      5'h0d: alarmCode = 12'h032;
      5'h0e: alarmCode = 12'h033;
      5'h0f: alarmCode = 12'h034;
      5'h10: alarmCode = 12'h035;
      5'h11: alarmCode = 12'h036;
      5'h12: alarmCode = 12'h037;
      5'h13: alarmCode = 12'h045;
      5'h14: alarmCode = 12'h046;
      5'h15: alarmCode = 12'h047;
      5'h16: alarmCode = 12'h050;
      5'h17: alarmCode = 12'h051;
      5'h18: alarmCode = 12'h052;
      5'h19: alarmCode = 12'h08a;
      5'h1a: alarmCode = 12'h08e;
      5'h1b: alarmCode = 12'h888;
      default: alarmCode = CODE_NONE;
    endcase
  endfunction

  // Clear class of each alarm index.
  function automatic logic [1:0] clearClass(input logic [IDX_W-1:0] idx);
    case (idx)
      5'h00, 5'h09, 5'h0c, 5'h10, 5'h11, 5'h19, 5'h1a: clearClass = CLR_RESET;
      5'h0f: clearClass = CLR_RX1;
      5'h0b, 5'h13, 5'h14, 5'h16, 5'h17: clearClass = CLR_THERMAL;
      default: clearClass = CLR_POWER;
    endcase
  endfunction

  // Display code of each warning index.
  function automatic logic [CODE_W-1:0] warnCode(input logic [IDX_W-1:0] idx);
    case (idx)
      5'h00: warnCode = 12'h092;
      5'h01: warnCode = 12'h096;
      5'h02: warnCode = 12'h09f;
      5'h03: warnCode = 12'h0e0;
      5'h04: warnCode = 12'h0e1;
      5'h05: warnCode = 12'h0e3;
      5'h06: warnCode = 12'h0e4;
      5'h07: warnCode = 12'h0e6;
      5'h08: warnCode = 12'h0e8;
      5'h09: warnCode = 12'h0e9;
      5'h0a: warnCode = 12'h0e7;
      5'h0b: warnCode = 12'h0ec;
      5'h0c: warnCode = 12'h0ed;
      default: warnCode = CODE_NONE;
    endcase
  endfunction

  // Lockout length in ticks computed from the averaged load.
  function automatic logic [TICK_W-1:0] lockTicks(input logic [LOAD_W-1:0] avg);
    lockTicks = LOCK_BASE_TICKS + TICK_W'(avg);
  endfunction

endpackage

//--- src/sam_alarm_manager.sv
`timescale 1ns/10ps
// Notes on behaviour
// - A fault during operation latches its alarm and shows its code; a warning shows only while present.
// - Reset-class alarms clear by power cycle, error reset or CPU reset.
// - Hard alarms clear only by power cycle; reset commands are ignored.
// - Receive error one clears by power cycle, CPU or error reset; cause may relatch.
// - Thermal alarms refuse controller clears until the lockout interval ends.
// - The lockout length is computed from load observed before the alarm.
// - Any alarm drops the fault-free output and engages the dynamic brake.
// - Control power lost sixty milliseconds continuously raises undervoltage.
// - Warnings use their own code set, distinct from alarm codes.
module sam_alarm_manager #(
  parameter int PWR_LOSS_CYCLES = sam_pkg::PWR_LOSS_CYCLES,
  parameter int LOCK_TICK_CYCLES = sam_pkg::LOCK_TICK_CYCLES
) (
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic rstn,
  // Fault and warning conditions from the drive logic.
  input wire logic [sam_pkg::NUM_ALARMS-1:0] faultIn,
  input wire logic [sam_pkg::NUM_WARNS-1:0] warnIn,
  input wire logic [sam_pkg::LOAD_W-1:0] loadLevel,
  // Control power monitor pin.
  input wire logic ctrlPowerOk,
  // Commands from the controller.
  input wire logic errReset,
  input wire logic cpuReset,
  // Status outputs.
  output logic faultFreeOut,
  output logic dynBrakeOn,
  output logic alarmActive,
  output logic warnActive,
  output logic [sam_pkg::CODE_W-1:0] displayCode
);

  sam_pkg::sam_state_t state_reg;
  logic [sam_pkg::IDX_W-1:0] alarmIdx_reg;
  logic pwrMeta_reg;
  logic pwrOk_reg;
  logic [31:0] lowCnt_reg;
  logic uvTrip_reg;
  logic [sam_pkg::NUM_ALARMS-1:0] faultVec;
  logic anyFault;
  logic [sam_pkg::IDX_W-1:0] firstFault;
  logic anyWarn;
  logic [sam_pkg::IDX_W-1:0] firstWarn;
  logic [1:0] curClass;
  logic anyCmd;
  logic clearOk;
  logic thermalLocked;
  logic lockStart;
  logic faultFree_reg;
  logic brake_reg;
  logic alarmOn_reg;
  logic warnOn_reg;
  logic [sam_pkg::CODE_W-1:0] display_reg;

  // Lowest set bit of a vector, used for alarm and warning priority.
  function automatic logic [sam_pkg::IDX_W-1:0] firstSet(input logic [31:0] vec);
    firstSet = 5'h00;
    for (int i = 31; i >= 0; i--)
      if (vec[i])
        firstSet = 5'(i);
  endfunction

  // Two-stage synchroniser for the control power pin.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwrMeta_reg <= 1'b1;
      pwrOk_reg <= 1'b1;
    end
    else
    begin
      pwrMeta_reg <= ctrlPowerOk;
      pwrOk_reg <= pwrMeta_reg;
    end
  end

  // Continuous loss counter; trips once the loss lasts the full interval.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lowCnt_reg <= 32'h0;
      uvTrip_reg <= 1'b0;
    end
    else if (pwrOk_reg)
    begin
      lowCnt_reg <= 32'h0;
      uvTrip_reg <= 1'b0;
    end
    else if (lowCnt_reg == 32'(PWR_LOSS_CYCLES - 1))
      uvTrip_reg <= 1'b1;
    else
      lowCnt_reg <= lowCnt_reg + 32'h1;
  end

  // Fault vector with the undervoltage detector merged in.
  always_comb
  begin
    faultVec = faultIn;
    faultVec[sam_pkg::IDX_UNDERVOLT] = faultIn[sam_pkg::IDX_UNDERVOLT] | uvTrip_reg;
    anyFault = |faultVec;
    firstFault = firstSet(32'(faultVec));
    anyWarn = |warnIn;
    firstWarn = firstSet(32'(warnIn));
  end

  // Clear qualification by class of the latched alarm.
  always_comb
  begin
    curClass = sam_pkg::clearClass(alarmIdx_reg);
    anyCmd = errReset | cpuReset;
    case (curClass)
      sam_pkg::CLR_RESET: clearOk = anyCmd;
      sam_pkg::CLR_RX1: clearOk = anyCmd;
      sam_pkg::CLR_THERMAL: clearOk = anyCmd & ~thermalLocked;
      default: clearOk = 1'b0;
    endcase
  end

  // Arm the lockout when a thermal alarm is latched.
  assign lockStart = anyFault && (state_reg == sam_pkg::ST_RUN || clearOk)
                     && sam_pkg::clearClass(firstFault) == sam_pkg::CLR_THERMAL;

  sam_lockout_timer #(
    .TICK_CYCLES(LOCK_TICK_CYCLES)
  ) u_lockout (
    .clk(clk),
    .rstn(rstn),
    .loadLevel(loadLevel),
    .start(lockStart),
    .locked(thermalLocked)
  );

  // Alarm latch; a fault present during a clear wins and relatches.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= sam_pkg::ST_RUN;
      alarmIdx_reg <= 5'h00;
    end
    else
    begin
      case (state_reg)
        sam_pkg::ST_RUN:
          if (anyFault)
          begin
            state_reg <= sam_pkg::ST_ALARM;
            alarmIdx_reg <= firstFault;
          end
        sam_pkg::ST_ALARM:
          if (clearOk)
          begin
            if (anyFault)
              alarmIdx_reg <= firstFault;
            else
              state_reg <= sam_pkg::ST_RUN;
          end
        default:
          state_reg <= sam_pkg::ST_RUN;
      endcase
    end
  end

  // Fault-free output and dynamic brake follow the latch.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      faultFree_reg <= 1'b0;
      brake_reg <= 1'b1;
      alarmOn_reg <= 1'b0;
    end
    else
    begin
      faultFree_reg <= (state_reg == sam_pkg::ST_RUN);
      brake_reg <= (state_reg == sam_pkg::ST_ALARM);
      alarmOn_reg <= (state_reg == sam_pkg::ST_ALARM);
    end
  end

  // Display shows the alarm code, else the first warning code.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      display_reg <= sam_pkg::CODE_NONE;
      warnOn_reg <= 1'b0;
    end
    else
    begin
      warnOn_reg <= anyWarn;
      if (state_reg == sam_pkg::ST_ALARM)
        display_reg <= sam_pkg::alarmCode(alarmIdx_reg);
      else if (anyWarn)
        display_reg <= sam_pkg::warnCode(firstWarn);
      else
        display_reg <= sam_pkg::CODE_NONE;
    end
  end

  assign faultFreeOut = faultFree_reg;
  assign dynBrakeOn = brake_reg;
  assign alarmActive = alarmOn_reg;
  assign warnActive = warnOn_reg;
  assign displayCode = display_reg;

  a_alarm_stops_motor: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == sam_pkg::ST_ALARM |=> !faultFree_reg && brake_reg)
    else $error("Alarm did not drop fault-free output or engage brake.");

  a_alarm_display: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == sam_pkg::ST_RUN && anyFault
    |=> ##1 display_reg == sam_pkg::alarmCode($past(firstFault, 2)))
    else $error("Display does not show the latched alarm code.");

  a_power_only: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == sam_pkg::ST_ALARM && curClass == sam_pkg::CLR_POWER
    |=> state_reg == sam_pkg::ST_ALARM && $stable(alarmIdx_reg))
    else $error("Power-cycle-only alarm was cleared by a command.");

  a_reset_clear: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == sam_pkg::ST_ALARM && curClass == sam_pkg::CLR_RESET
    && (errReset || cpuReset) && !anyFault |=> state_reg == sam_pkg::ST_RUN)
    else $error("Resettable alarm was not cleared by a reset command.");

  a_rx1_clear: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == sam_pkg::ST_ALARM && curClass == sam_pkg::CLR_RX1 && cpuReset
    && !anyFault |=> state_reg == sam_pkg::ST_RUN ##1 faultFree_reg)
    else $error("Receive error one was not cleared by CPU reset.");

  a_thermal_lock: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == sam_pkg::ST_ALARM && curClass == sam_pkg::CLR_THERMAL && thermalLocked
    |=> state_reg == sam_pkg::ST_ALARM)
    else $error("Thermal alarm cleared during lockout.");

  a_uv_trip: assert property (@(posedge clk) disable iff (!rstn)
    !pwrOk_reg && lowCnt_reg == 32'(PWR_LOSS_CYCLES - 1) |=> uvTrip_reg ##1
    state_reg == sam_pkg::ST_ALARM)
    else $error("Undervoltage not raised after the loss interval.");

  a_warn_code: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == sam_pkg::ST_RUN && anyWarn
    |=> warnOn_reg && display_reg == sam_pkg::warnCode($past(firstWarn)))
    else $error("Warning code not shown from the warning set.");

  a_hold_alarm: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == sam_pkg::ST_ALARM && !clearOk
    |=> state_reg == sam_pkg::ST_ALARM && $stable(alarmIdx_reg) ##1 !faultFree_reg)
    else $error("Latched alarm changed without a permitted clear.");

endmodule

//--- src/sam_lockout_timer.sv
`timescale 1ns/10ps
module sam_lockout_timer #(
  parameter int TICK_CYCLES = sam_pkg::LOCK_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Load observation and start.
  input wire logic [sam_pkg::LOAD_W-1:0] loadLevel,
  input wire logic start,
  // Lockout state.
  output logic locked
);

  logic [31:0] tickCnt_reg;
  logic tick;
  logic [sam_pkg::LOAD_W-1:0] loadAvg_reg;
  logic [sam_pkg::TICK_W-1:0] ticksLeft_reg;

  // Free running tick divider.
  assign tick = (tickCnt_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tickCnt_reg <= 32'h0;
    else if (tick)
      tickCnt_reg <= 32'h0;
    else
      tickCnt_reg <= tickCnt_reg + 32'h1;
  end

  // First order filter of the load, updated on every tick whether or not an alarm is latched.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      loadAvg_reg <= 8'h00;
    else if (tick)
      loadAvg_reg <= loadAvg_reg - (loadAvg_reg >> sam_pkg::LOAD_SHIFT)
                     + (loadLevel >> sam_pkg::LOAD_SHIFT);
  end

  // Lockout countdown, loaded from the computed length on start.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ticksLeft_reg <= 16'h0000;
    else if (start)
      ticksLeft_reg <= sam_pkg::lockTicks(loadAvg_reg);
    else if (tick && ticksLeft_reg != 16'h0000)
      ticksLeft_reg <= ticksLeft_reg - 16'h0001;
  end

  assign locked = (ticksLeft_reg != 16'h0000);

  a_lock_length: assert property (@(posedge clk) disable iff (!rstn)
    start |=> ticksLeft_reg == sam_pkg::lockTicks($past(loadAvg_reg)))
    else $error("Lockout length does not match the averaged load.");

endmodule

//--- test/sam_ctrl_model.sv
`timescale 1ns/10ps
// Behavioural controller that sends clear commands over the command link.
module sam_ctrl_model (
  // Clock.
  input wire logic clk,
  // Clear commands to the device.
  output logic errReset,
  output logic cpuReset
);
  // Both commands stay idle until the controller decides to clear.
  initial
  begin
    errReset = 1'b0;
    cpuReset = 1'b0;
  end

  // Waits the chosen number of cycles, then sends one command for one cycle.
  task automatic issue(input int kind, input int waitCycles);
    repeat (waitCycles) @(negedge clk);
    if (kind == 0)
      errReset = 1'b1;
    else
      cpuReset = 1'b1;
    @(negedge clk);
    errReset = 1'b0;
    cpuReset = 1'b0;
  endtask

  // Home position setting after a position erase; no command is sent meanwhile.
  task automatic homeSet(input int cycles);
    repeat (cycles) @(negedge clk);
  endtask
endmodule

//--- test/test_servo_alarm_manager.sv
`timescale 1ns/10ps
// Self-checking bench for the alarm manager driven by a behavioural controller.
module test_servo_alarm_manager;
  // Design inputs and outputs.
  logic clk;
  logic rstn;
  logic [27:0] faultIn;
  logic [12:0] warnIn;
  logic [7:0] loadLevel;
  logic ctrlPowerOk;
  wire logic errReset;
  wire logic cpuReset;
  wire logic faultFreeOut;
  wire logic dynBrakeOn;
  wire logic alarmActive;
  wire logic warnActive;
  wire logic [11:0] displayCode;
  // Bookkeeping: notes of expected output states and the code tables.
  int failCount = 0;
  int numChecks = 0;
  int seed = 32'he2af;
  logic [15:0] expQ[$];
  logic [15:0] outPrev;
  wire logic [15:0] outNow = {faultFreeOut, dynBrakeOn, alarmActive, warnActive, displayCode};
  logic [11:0] aCode [28] = '{12'h010, 12'h012, 12'h013, 12'h015, 12'h016, 12'h017, 12'h019,
    12'h01a, 12'h020, 12'h024, 12'h025, 12'h030, 12'h031, 12'h032, 12'h033, 12'h034, 12'h035,
    12'h036, 12'h037, 12'h045, 12'h046, 12'h047, 12'h050, 12'h051, 12'h052, 12'h08a, 12'h08e,
    12'h888};
  logic [11:0] wCode [13] = '{12'h092, 12'h096, 12'h09f, 12'h0e0, 12'h0e1, 12'h0e3, 12'h0e4,
    12'h0e6, 12'h0e8, 12'h0e9, 12'h0e7, 12'h0ec, 12'h0ed};
  logic [27:0] rstMask = 28'h6031201;

  // Short counts keep the power-loss and lockout waits affordable.
  sam_alarm_manager #(.PWR_LOSS_CYCLES(20), .LOCK_TICK_CYCLES(4)) i_sam_alarm_manager (
    .clk(clk), .rstn(rstn), .faultIn(faultIn), .warnIn(warnIn), .loadLevel(loadLevel),
    .ctrlPowerOk(ctrlPowerOk), .errReset(errReset), .cpuReset(cpuReset),
    .faultFreeOut(faultFreeOut), .dynBrakeOn(dynBrakeOn), .alarmActive(alarmActive),
    .warnActive(warnActive), .displayCode(displayCode));
  sam_ctrl_model i_sam_ctrl_model (.clk(clk), .errReset(errReset), .cpuReset(cpuReset));

  // Free-running 250 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [15:0] expv, input logic [15:0] got);
    numChecks++;
    if (got !== expv)
    begin
      failCount++;
      $display("Error %s expected %h seen %h", what, expv, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finishTest();
    $display("Checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Power off then on; outputs must show the fault state while held.
  task automatic powerCycle();
    rstn = 1'b0;
    repeat (20) @(negedge clk);
    check("reset outputs", 16'h4000, outNow);
    expQ.push_back(16'h8000);
    rstn = 1'b1;
  endtask

  // Raises one fault for one cycle and notes the latched state.
  task automatic latch(input int i, input logic [15:0] base);
    faultIn[i] = 1'b1;
    expQ.push_back(base | 16'(aCode[i]));
    @(negedge clk);
    faultIn[i] = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // Each change of the outputs takes the oldest note and compares with it.
  always @(negedge clk)
  begin
    if (rstn === 1'b1 && outNow !== outPrev)
    begin
      if (expQ.size() == 0)
        check("unexpected change", outPrev, outNow);
      else
        check("outputs", expQ.pop_front(), outNow);
    end
    outPrev = outNow;
  end

  // Cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge clk);
    failCount++;
    finishTest();
  end

  // Main sequence.
  initial
  begin
    int j;
    int flo;
    int wlo;
    logic [27:0] f;
    logic [12:0] w;
    faultIn = '0;
    warnIn = '0;
    loadLevel = '0;
    ctrlPowerOk = 1'b1;
    rstn = 1'b0;
    @(negedge clk);
    powerCycle();
    repeat (2) @(negedge clk);
    // Every alarm against both commands, with a second fault tried while latched.
    for (int i = 0; i < 28; i++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        loadLevel = 8'($random(seed));
        latch(i, 16'h6000);
        faultIn[(i + 1) % 28] = 1'b1;
        @(negedge clk);
        faultIn[(i + 1) % 28] = 1'b0;
        if (rstMask[i] || i == 15)
          expQ.push_back(16'h8000);
        i_sam_ctrl_model.issue(c, 0);
        repeat (3) @(negedge clk);
        if (!(rstMask[i] || i == 15))
        begin
          check("refused clear", 16'h6000 | 16'(aCode[i]), outNow);
          powerCycle();
          repeat (2) @(negedge clk);
          if (i == 10)
            i_sam_ctrl_model.homeSet(10);
        end
      end
    end
    $display("Test clear methods done");
    // Receive error one with its cause still present relatches at once.
    faultIn[15] = 1'b1;
    expQ.push_back(16'h6034);
    repeat (3) @(negedge clk);
    i_sam_ctrl_model.issue(0, 0);
    repeat (3) @(negedge clk);
    check("relatch", 16'h6034, outNow);
    faultIn[15] = 1'b0;
    expQ.push_back(16'h8000);
    i_sam_ctrl_model.issue(1, 1);
    repeat (3) @(negedge clk);
    $display("Test receive error done");
    // Power loss just short of the limit, then long enough to trip.
    ctrlPowerOk = 1'b0;
    repeat (10 + {$random(seed)} % 9) @(negedge clk);
    ctrlPowerOk = 1'b1;
    repeat (10) @(negedge clk);
    check("short loss", 16'h8000, outNow);
    ctrlPowerOk = 1'b0;
    expQ.push_back(16'h6010);
    repeat (20) @(negedge clk);
    check("early trip", 16'h8000, outNow);
    repeat (10) @(negedge clk);
    check("trip", 16'h6010, outNow);
    ctrlPowerOk = 1'b1;
    expQ.push_back(16'h8000);
    i_sam_ctrl_model.issue(0, 5);
    repeat (3) @(negedge clk);
    $display("Test undervoltage done");
    // Every warning code, then a random warning under an alarm.
    for (int k = 0; k < 13; k++)
    begin
      warnIn[k] = 1'b1;
      expQ.push_back(16'h9000 | 16'(wCode[k]));
      repeat (2) @(negedge clk);
      warnIn[k] = 1'b0;
      expQ.push_back(16'h8000);
      repeat (2) @(negedge clk);
    end
    j = {$random(seed)} % 13;
    warnIn[j] = 1'b1;
    expQ.push_back(16'h9000 | 16'(wCode[j]));
    repeat (2) @(negedge clk);
    latch(9, 16'h7000);
    expQ.push_back(16'h9000 | 16'(wCode[j]));
    i_sam_ctrl_model.issue(0, 0);
    repeat (2) @(negedge clk);
    warnIn[j] = 1'b0;
    expQ.push_back(16'h8000);
    repeat (3) @(negedge clk);
    // Random fault and warning sets: the lowest index of each is shown.
    for (int n = 0; n < 8; n++)
    begin
      w = 13'($random(seed)) | 13'h1000;
      f = (28'($random(seed)) & rstMask) | 28'h4000000;
      flo = 0;
      wlo = 0;
      for (int b = 27; b >= 0; b--)
        if (f[b])
          flo = b;
      for (int b = 12; b >= 0; b--)
        if (w[b])
          wlo = b;
      warnIn = w;
      expQ.push_back(16'h9000 | 16'(wCode[wlo]));
      repeat (2) @(negedge clk);
      faultIn = f;
      expQ.push_back(16'h7000 | 16'(aCode[flo]));
      @(negedge clk);
      faultIn = '0;
      repeat (3) @(negedge clk);
      expQ.push_back(16'h9000 | 16'(wCode[wlo]));
      i_sam_ctrl_model.issue(n % 2, 0);
      repeat (2) @(negedge clk);
      warnIn = '0;
      expQ.push_back(16'h8000);
      repeat (3) @(negedge clk);
    end
    $display("Test warnings done");
    // Light load: lockout near 4000 cycles, so the load history starts empty.
    loadLevel = 8'h00;
    powerCycle();
    repeat (100) @(negedge clk);
    latch(11, 16'h6000);
    i_sam_ctrl_model.issue(0, 3880);
    check("lockout light", 16'h6030, outNow);
    expQ.push_back(16'h8000);
    i_sam_ctrl_model.issue(1, 200);
    repeat (3) @(negedge clk);
    // Heavy load before the alarm stretches the lockout.
    loadLevel = 8'hff;
    repeat (1000) @(negedge clk);
    latch(22, 16'h6000);
    i_sam_ctrl_model.issue(0, 4300);
    check("lockout heavy", 16'h6050, outNow);
    expQ.push_back(16'h8000);
    i_sam_ctrl_model.issue(0, 900);
    repeat (5) @(negedge clk);
    $display("Test thermal lockout done");
    check("notes left", 16'h0000, 16'(expQ.size()));
    finishTest();
  end
endmodule
